// [core/dpsm_copy.sv]
// Staged-to-active control set copy engine for one data path.
// Assumes start pulses only arrive while busy is low.
`timescale 1ns/100ps
`default_nettype none
module dpsm_copy
    import dpsm_pkg::*;
#(
    parameter int LANES = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic start_with_init,
    input wire logic [LANES-1:0] start_lanes,
    input wire logic copy_error,
    output logic busy,
    output logic done,
    output logic done_with_init,
    output logic [LANES-1:0] done_lanes
);
    logic [7:0] count;
    logic with_init;

    // ============================================================
    // Copy timer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            count <= 8'h00;
        end else if (start && !busy) begin
            busy <= 1'b1;
            count <= 8'(COPY_CYCLES - 1);
        end else if (busy) begin
            if (count == 8'h00) begin
                busy <= 1'b0;
            end else begin
                count <= count - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            with_init <= 1'b0;
            done_lanes <= '0;
        end else if (start && !busy) begin
            with_init <= start_with_init;
            done_lanes <= start_lanes;
        end
    end

    // A failed copy reports no completion at all
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            done_with_init <= 1'b0;
        end else begin
            done <= busy && (count == 8'h00) && !copy_error;
            done_with_init <= busy && (count == 8'h00) && !copy_error && with_init;
        end
    end
endmodule
`default_nettype wire

// [core/dpsm_core.sv]
// Data path state machine for one data path, with its control registers.
// Assumes module-level state arrives as synchronous levels and that the
// data path resources report completion by one-cycle done pulses.
//
// What this block does
// - Redeinit is deinit OR pending term
// - Pending term ORs all host lanes
// - Apply-with-init copy sets pending lanes together
// - Apply-now copy never sets pending bits
// - Pending bits cleared while initializing
// - No-hitless: redeinit equals deinit only
// - Deactivate ORs redeinit, disable, squelch terms
// - Disable/squelch terms OR all media lanes
// - One lane off drives path to ready
// - Module reset tears down the path
// - Module fault overrides path behaviour
// - Idle: Tx quiet, go init when not deinit
// - Init: Tx quiet, teardown or ready
// - Ready: Tx quiet, teardown or enable
// - Teardown: deinitialize, then go idle
// - Enabling/active exit on deactivate signal
// - Disabling returns ready when outputs off
// - Initialized Rx forwards in four states
// - Rx muted in idle, init, teardown
// - Host Rx off always mutes
// - Enabled auto squelch mutes Rx
// - Rx status always shows actual output
// - Deinit from module state, power, lanes
// - Path starts in idle state
`timescale 1ns/100ps
`default_nettype none
module dpsm_core
    import dpsm_pkg::*;
#(
    parameter int LANES = 8,
    parameter int MLANES = 8,
    parameter bit NO_HITLESS_RECONFIG_ADV = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Module state machine
    input wire logic module_ready,
    input wire logic low_power_signal,
    input wire logic module_reset_signal,
    input wire logic module_fault_state,
    // Data path resources
    input wire logic init_done,
    input wire logic deinit_done,
    input wire logic tx_on_done,
    input wire logic tx_off_done,
    input wire logic copy_error,
    input wire logic [LANES-1:0] rx_in_valid,
    input wire logic [LANES-1:0] rx_sq_cond,
    output logic [MLANES-1:0] tx_out_enable,
    output logic [LANES-1:0] rx_out_enable,
    output logic [6:0] path_state,
    output logic path_exists
);
    // ============================================================
    // Register storage
    logic [LANES-1:0] lane_deinit_ctrl;
    logic [MLANES-1:0] tx_lane_out_off_ctrl;
    logic [MLANES-1:0] tx_lane_force_mute_ctrl;
    logic [LANES-1:0] rx_out_off_ctrl;
    logic [LANES-1:0] rx_auto_sq_en;
    logic [LANES-1:0] lane_init_pending_bit;
    logic rx_res_ready;
    logic ack;
    logic [31:0] next_readdata;

    dpsm_state_t state;
    dpsm_state_t next_state;

    logic path_deinit_signal;
    logic path_redeinit_signal;
    logic path_deactivate_signal;
    logic reinit_pending_term;
    logic tx_disable_any_term;
    logic tx_squelch_any_term;
    logic sm_run;

    logic copy_start;
    logic copy_start_init;
    logic copy_busy;
    logic copy_done;
    logic copy_done_init;
    logic [LANES-1:0] copy_lanes;
    logic [LANES-1:0] rx_out_status;
    logic [31:0] merged_deinit;
    logic [31:0] merged_tx;
    logic [31:0] merged_rx;

    wire logic req = avs_read || avs_write;
    // Write lands at the edge that sees waitrequest low
    wire logic wr_take = avs_write && ack;

    // Byte-merged register words, sliced into fields below
    assign merged_deinit = dpsm_merge(32'(lane_deinit_ctrl), avs_writedata, avs_byteenable);
    assign merged_tx = dpsm_merge({16'h0000, tx_lane_force_mute_ctrl, tx_lane_out_off_ctrl},
        avs_writedata, avs_byteenable);
    assign merged_rx = dpsm_merge({16'h0000, rx_auto_sq_en, rx_out_off_ctrl},
        avs_writedata, avs_byteenable);

    // ============================================================
    // Avalon-MM slave: one wait state, answer on the second edge
    assign avs_waitrequest = req && !ack;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            OFS_DEINIT: next_readdata[LANES-1:0] = lane_deinit_ctrl;
            OFS_TX_CTRL: begin
                next_readdata[MLANES-1:0] = tx_lane_out_off_ctrl;
                next_readdata[FLD_HI_LSB +: MLANES] = tx_lane_force_mute_ctrl;
            end
            OFS_RX_CTRL: begin
                next_readdata[LANES-1:0] = rx_out_off_ctrl;
                next_readdata[FLD_HI_LSB +: LANES] = rx_auto_sq_en;
            end
            OFS_STATUS: begin
                next_readdata[FLD_STATE_LSB +: 7] = state;
                next_readdata[FLD_PENDING_LSB +: LANES] = lane_init_pending_bit;
                next_readdata[FLD_EXISTS] = path_exists;
                next_readdata[FLD_NO_HITLESS] = NO_HITLESS_RECONFIG_ADV;
                next_readdata[FLD_COPY_BUSY] = copy_busy;
            end
            OFS_RX_STATUS: next_readdata[LANES-1:0] = rx_out_status;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // Data captured on the first edge stands at the accepting edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lane_deinit_ctrl <= RST_DEINIT[LANES-1:0];
        end else if (wr_take && avs_address == OFS_DEINIT) begin
            lane_deinit_ctrl <= merged_deinit[LANES-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_lane_out_off_ctrl <= RST_TX_CTRL[MLANES-1:0];
            tx_lane_force_mute_ctrl <= RST_TX_CTRL[FLD_HI_LSB +: MLANES];
        end else if (wr_take && avs_address == OFS_TX_CTRL) begin
            tx_lane_out_off_ctrl <= merged_tx[MLANES-1:0];
            tx_lane_force_mute_ctrl <= merged_tx[FLD_HI_LSB +: MLANES];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_out_off_ctrl <= RST_RX_CTRL[LANES-1:0];
            rx_auto_sq_en <= RST_RX_CTRL[FLD_HI_LSB +: LANES];
        end else if (wr_take && avs_address == OFS_RX_CTRL) begin
            rx_out_off_ctrl <= merged_rx[LANES-1:0];
            rx_auto_sq_en <= merged_rx[FLD_HI_LSB +: LANES];
        end
    end

    // ============================================================
    // Apply triggers: lane mask in the low byte; ignored while busy
    assign copy_start = wr_take && !copy_busy && (avs_address == OFS_APPLY_INIT0
        || avs_address == OFS_APPLY_INIT1 || avs_address == OFS_APPLY_NOW);
    assign copy_start_init = avs_address != OFS_APPLY_NOW;

    dpsm_copy #(
        .LANES(LANES)
    ) u_copy (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(copy_start),
        .start_with_init(copy_start_init),
        .start_lanes(avs_writedata[LANES-1:0]),
        .copy_error(copy_error),
        .busy(copy_busy),
        .done(copy_done),
        .done_with_init(copy_done_init),
        .done_lanes(copy_lanes)
    );

    // Set beats the clear in the same cycle; the path then cycles again
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lane_init_pending_bit <= '0;
        end else if (module_reset_signal) begin
            lane_init_pending_bit <= '0;
        end else if (copy_done_init) begin
            lane_init_pending_bit <= lane_init_pending_bit | copy_lanes;
        end else if (state == ST_INIT) begin
            lane_init_pending_bit <= '0;
        end
    end

    // ============================================================
    // Transition signals
    assign path_deinit_signal = !module_ready || low_power_signal || (|lane_deinit_ctrl);
    assign reinit_pending_term = |lane_init_pending_bit;
    assign path_redeinit_signal = path_deinit_signal
        || (!NO_HITLESS_RECONFIG_ADV && reinit_pending_term);
    assign tx_disable_any_term = |tx_lane_out_off_ctrl;
    assign tx_squelch_any_term = |tx_lane_force_mute_ctrl;
    assign path_deactivate_signal = path_redeinit_signal || tx_disable_any_term
        || tx_squelch_any_term;

    // Fault freezes the machine until it clears; a module reset still forces idle
    assign sm_run = !module_reset_signal && !module_fault_state;

    // ============================================================
    // State machine
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (!path_deinit_signal) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (path_deinit_signal) begin
                    next_state = ST_TEARDOWN;
                end else if (init_done) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (path_redeinit_signal) begin
                    next_state = ST_TEARDOWN;
                end else if (!path_deactivate_signal) begin
                    next_state = ST_TX_ON;
                end
            end
            ST_TEARDOWN: begin
                if (deinit_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_TX_ON: begin
                if (path_deactivate_signal) begin
                    next_state = ST_TX_OFF;
                end else if (tx_on_done) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (path_deactivate_signal) begin
                    next_state = ST_TX_OFF;
                end
            end
            ST_TX_OFF: begin
                if (tx_off_done) begin
                    next_state = ST_READY;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (module_reset_signal) begin
            state <= ST_IDLE;
        end else if (sm_run) begin
            state <= next_state;
        end
    end

    // Instance is gone under module reset, recreated after it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            path_exists <= 1'b0;
        end else begin
            path_exists <= !module_reset_signal;
        end
    end

    assign path_state = state;

    // ============================================================
    // Tx outputs: quiet unless turning on or active, per-lane gated
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_out_enable <= '0;
        end else if (!sm_run) begin
            tx_out_enable <= '0;
        end else begin
            tx_out_enable <= {MLANES{state == ST_TX_ON || state == ST_ACTIVE}}
                & ~tx_lane_out_off_ctrl & ~tx_lane_force_mute_ctrl;
        end
    end

    // ============================================================
    // Rx path: resources count as ready after the first init pass
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_res_ready <= 1'b0;
        end else if (module_reset_signal) begin
            rx_res_ready <= 1'b0;
        end else if (state == ST_INIT && next_state == ST_READY && sm_run) begin
            rx_res_ready <= 1'b1;
        end
    end

    dpsm_rx_out #(
        .LANES(LANES)
    ) u_rx (
        .ref_clk(ref_clk),
        .rst(rst),
        .forward(rx_res_ready && dpsm_rx_fwd(state) && sm_run),
        .rx_in_valid(rx_in_valid),
        .rx_out_off_ctrl(rx_out_off_ctrl),
        .rx_auto_sq_en(rx_auto_sq_en),
        .rx_sq_cond(rx_sq_cond),
        .rx_out_enable(rx_out_enable)
    );

    // Status reads the driven output itself
    assign rx_out_status = rx_out_enable;

    // ============================================================
    // Checks
    sequence s_turn_off;
        state == ST_ACTIVE ##1 state == ST_TX_OFF;
    endsequence

    chk_idle_exit: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_IDLE && !path_deinit_signal && sm_run |=> state == ST_INIT)
        else $error("idle did not start init");
    chk_init_abort: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_INIT && path_deinit_signal && sm_run |=> state == ST_TEARDOWN)
        else $error("init did not abort to teardown");
    chk_ready_teardown: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_READY && path_redeinit_signal && sm_run |=> state == ST_TEARDOWN)
        else $error("ready ignored redeinit");
    chk_lane_off_exit: assert property (@(posedge ref_clk) disable iff (rst)
        (state == ST_ACTIVE || state == ST_TX_ON) && tx_disable_any_term && sm_run
        |=> state == ST_TX_OFF)
        else $error("lane disable did not turn path off");
    chk_off_to_ready: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_TX_OFF && tx_off_done && sm_run |=> state == ST_READY)
        else $error("turn-off did not return to ready");
    chk_off_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        s_turn_off |=> tx_out_enable == '0)
        else $error("tx still on after turn-off");
    chk_pending_set: assert property (@(posedge ref_clk) disable iff (rst)
        copy_done_init && !module_reset_signal
        |=> (lane_init_pending_bit & $past(copy_lanes)) == $past(copy_lanes))
        else $error("pending bits not set after copy");
    chk_now_no_pending: assert property (@(posedge ref_clk) disable iff (rst)
        copy_done && !copy_done_init |=> (lane_init_pending_bit & ~$past(lane_init_pending_bit)) == '0)
        else $error("apply-now set pending bits");
    chk_pending_clear: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_INIT && !copy_done_init |=> lane_init_pending_bit == '0)
        else $error("pending bits not cleared in init");
    chk_rx_host_mute: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (rx_out_status & $past(rx_out_off_ctrl)) == '0)
        else $error("rx output on while host mute");
    chk_reset_gone: assert property (@(posedge ref_clk) disable iff (rst)
        module_reset_signal |=> state == ST_IDLE && !path_exists && tx_out_enable == '0)
        else $error("path not torn down on module reset");
    chk_one_state: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot(state))
        else $error("path state not one-hot");
endmodule
`default_nettype wire

// [core/dpsm_rx_out.sv]
// Registered Rx host-lane output gating for one data path.
// Assumes the enable terms are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dpsm_rx_out
    import dpsm_pkg::*;
#(
    parameter int LANES = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic forward,
    input wire logic [LANES-1:0] rx_in_valid,
    input wire logic [LANES-1:0] rx_out_off_ctrl,
    input wire logic [LANES-1:0] rx_auto_sq_en,
    input wire logic [LANES-1:0] rx_sq_cond,
    output logic [LANES-1:0] rx_out_enable
);
    // Host mute and auto squelch override every path state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_out_enable <= '0;
        end else begin
            rx_out_enable <= rx_in_valid & ~rx_out_off_ctrl & ~(rx_auto_sq_en & rx_sq_cond)
                & {LANES{forward}};
        end
    end
endmodule
`default_nettype wire

// [pkg/dpsm_pkg.sv]
// Shared constants for the data path state machine block.
// Assumes a single 40 MHz management clock and a 32-bit Avalon-MM slave.
package dpsm_pkg;

    // ============================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int COPY_TIME_NS = 500;
    // Least time, so rounded up
    localparam int COPY_CYCLES = (COPY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ============================================================
    // Register byte offsets
    localparam logic [5:0] OFS_DEINIT = 6'h00;
    localparam logic [5:0] OFS_TX_CTRL = 6'h04;
    localparam logic [5:0] OFS_RX_CTRL = 6'h08;
    localparam logic [5:0] OFS_APPLY_INIT0 = 6'h0C;
    localparam logic [5:0] OFS_APPLY_INIT1 = 6'h10;
    localparam logic [5:0] OFS_APPLY_NOW = 6'h14;
    localparam logic [5:0] OFS_STATUS = 6'h18;
    localparam logic [5:0] OFS_RX_STATUS = 6'h1C;

    // ============================================================
    // Field positions and reset values
    localparam int FLD_HI_LSB = 8;
    localparam int FLD_STATE_LSB = 0;
    localparam int FLD_PENDING_LSB = 8;
    localparam int FLD_EXISTS = 16;
    localparam int FLD_NO_HITLESS = 17;
    localparam int FLD_COPY_BUSY = 18;
    localparam logic [31:0] RST_DEINIT = 32'h0000_00FF;
    localparam logic [31:0] RST_TX_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_RX_CTRL = 32'h0000_0000;

    // ============================================================
    // Path states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_INIT = 7'h02,
        ST_READY = 7'h04,
        ST_TEARDOWN = 7'h08,
        ST_TX_ON = 7'h10,
        ST_ACTIVE = 7'h20,
        ST_TX_OFF = 7'h40
    } dpsm_state_t;

    // States in which initialized Rx resources must forward
    function automatic logic dpsm_rx_fwd(input dpsm_state_t s);
        return (s == ST_READY) || (s == ST_TX_ON) || (s == ST_TX_OFF) || (s == ST_ACTIVE);
    endfunction

    // Byte-enable merge of a write into a stored word
    function automatic logic [31:0] dpsm_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// [tb/dpsm_core_test.sv]
// Self-checking bench for the data path state machine core.
// Assumes the host model owns the register bus; the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module dpsm_core_test;
    import dpsm_pkg::*;
    typedef struct packed {logic [31:0] tx; logic [6:0] st; logic [7:0] ten;} dpsm_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, path_exists;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic module_ready = 1'b0, low_power_signal = 1'b0, module_reset_signal = 1'b0;
    logic module_fault_state = 1'b0, tx_on_done = 1'b0, copy_error = 1'b0;
    logic [7:0] rx_sq_cond = 8'h00, tx_out_enable, rx_out_enable;
    logic [6:0] path_state;
    int n_mismatch = 0;
    int n_checks = 0;
    // Lane 0 and lane 7 of each Tx term, each followed by a clear
    dpsm_row_t rows [8] = '{'{32'h1, ST_READY, 8'h0}, '{32'h0, ST_ACTIVE, 8'hFF},
        '{32'h80, ST_READY, 8'h0}, '{32'h0, ST_ACTIVE, 8'hFF},
        '{32'h100, ST_READY, 8'h0}, '{32'h0, ST_ACTIVE, 8'hFF},
        '{32'h8000, ST_READY, 8'h0}, '{32'h0, ST_ACTIVE, 8'hFF}};

    always #12.5 ref_clk = ~ref_clk;

    dpsm_host host (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata));

    dpsm_core dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .module_ready(module_ready),
        .low_power_signal(low_power_signal), .module_reset_signal(module_reset_signal),
        .module_fault_state(module_fault_state), .init_done(1'b1), .deinit_done(1'b1),
        .tx_on_done(tx_on_done), .tx_off_done(1'b1), .copy_error(copy_error),
        .rx_in_valid(8'hFF), .rx_sq_cond(rx_sq_cond), .tx_out_enable(tx_out_enable),
        .rx_out_enable(rx_out_enable), .path_state(path_state), .path_exists(path_exists));

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_st(input logic [6:0] s);
        for (int i = 0; i < 300 && path_state !== s; i++) begin
            @(posedge ref_clk);
        end
        check({25'h0, path_state}, {25'h0, s});
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] unused;
        host.xfer(1'b1, a, d, unused);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        finish_test;
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // Second edge: path_exists is only launched at the first one
        repeat (2) @(posedge ref_clk);
        check({25'h0, path_state}, {25'h0, ST_IDLE});
        check({31'h0, path_exists}, 32'h1);
        host.xfer(1'b0, OFS_DEINIT, 32'h0, q);
        check(q, RST_DEINIT);
        wr(6'h3C, 32'hFFFF_FFFF);
        host.xfer(1'b0, 6'h3C, 32'h0, q);
        check(q, 32'h0);
        module_ready <= 1'b1;
        wr(OFS_DEINIT, 32'h0);
        wait_st(ST_INIT);
        wait_st(ST_TX_ON);
        tx_on_done <= 1'b1;
        wait_st(ST_ACTIVE);
        $display("bring-up test done");
        foreach (rows[i]) begin
            wr(OFS_TX_CTRL, rows[i].tx);
            wait_st(rows[i].st);
            repeat (2) @(posedge ref_clk);
            check({24'h0, tx_out_enable}, {24'h0, rows[i].ten});
        end
        check({24'h0, rx_out_enable}, 32'hFF);
        rx_sq_cond <= 8'h02;
        wr(OFS_RX_CTRL, 32'h0201);
        repeat (2) @(posedge ref_clk);
        check({24'h0, rx_out_enable}, 32'hFC);
        host.xfer(1'b0, OFS_RX_STATUS, 32'h0, q);
        check(q, 32'hFC);
        wr(OFS_RX_CTRL, 32'h0);
        $display("tx and rx control test done");
        // First and last host lane, one through each apply-init register
        for (int k = 0; k < 2; k++) begin
            wr(k ? OFS_APPLY_INIT1 : OFS_APPLY_INIT0, k ? 32'h80 : 32'h1);
            wait_st(ST_TEARDOWN);
            wait_st(ST_ACTIVE);
            host.xfer(1'b0, OFS_STATUS, 32'h0, q);
            check({24'h0, q[15:8]}, 32'h0);
        end
        // Failed init copy, then apply-now: the path must never leave active
        for (int k = 0; k < 2; k++) begin
            copy_error <= (k == 0);
            wr(k ? OFS_APPLY_NOW : OFS_APPLY_INIT0, 32'hFF);
            q = 32'h0;
            repeat (40) begin
                @(posedge ref_clk);
                q = q | {25'h0, path_state ^ ST_ACTIVE};
            end
            check(q, 32'h0);
        end
        host.xfer(1'b0, OFS_STATUS, 32'h0, q);
        check({24'h0, q[15:8]}, 32'h0);
        $display("apply test done");
        low_power_signal <= 1'b1;
        wait_st(ST_IDLE);
        check({24'h0, rx_out_enable}, 32'h0);
        low_power_signal <= 1'b0;
        wait_st(ST_ACTIVE);
        module_fault_state <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({24'h0, tx_out_enable | rx_out_enable}, 32'h0);
        module_fault_state <= 1'b0;
        module_reset_signal <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({31'h0, path_exists}, 32'h0);
        check({25'h0, path_state}, {25'h0, ST_IDLE});
        module_reset_signal <= 1'b0;
        wait_st(ST_ACTIVE);
        $display("power, fault and reset test done");
        finish_test;
    end
endmodule
`default_nettype wire

// [tb/dpsm_host.sv]
// Host management controller model: Avalon-MM master for register access.
// Assumes callers enter xfer just after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dpsm_host (
    input wire logic ref_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end

    // ============================================================
    // One access, held until the accepting edge
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge so a following call never reasserts in the same step
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire
